//--- shared/fsq_pkg.sv
package fsq_pkg;
    // Register byte offsets, one aligned word each
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_DF_ACCESS   = 8'h00;
    localparam logic [7:0]  OFS_AREA_SELECT = 8'h04;
    localparam logic [7:0]  OFS_MAIN_SEQ    = 8'h08;
    localparam logic [7:0]  OFS_EXTRA_SEQ   = 8'h0C;
    localparam logic [7:0]  OFS_PROT_KEY    = 8'h10;
    localparam logic [7:0]  OFS_PROT_STATUS = 8'h14;
    localparam logic [7:0]  OFS_PROG_MODE   = 8'h18;
    localparam logic [7:0]  OFS_STATUS_HIGH = 8'h1C;
    localparam logic [7:0]  OFS_STATUS_LOW  = 8'h20;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h28;

    // Field positions
    localparam int          DF_ENABLE_BIT   = 0;
    localparam int          SEQ_START_BIT   = 7;
    localparam int          SEQ_STOP_BIT    = 6;
    localparam int          EXTRA_DONE_BIT  = 7;
    localparam int          MAIN_DONE_BIT   = 6;
    localparam int          ERR_EXTRA_BIT   = 5;
    localparam int          ERR_MAIN_BIT    = 4;
    localparam int          ERR_BLANK_BIT   = 3;
    localparam int          ERR_VERIFY_BIT  = 2;
    localparam int          ERR_WRITE_BIT   = 1;
    localparam int          ERR_ERASE_BIT   = 0;
    localparam int          PROT_ERR_BIT    = 0;
    localparam int          IRQ_MAIN_BIT    = 0;
    localparam int          IRQ_EXTRA_BIT   = 1;
    localparam int          IRQ_PROT_BIT    = 2;
    localparam int          IRQ_W           = 3;

    // Register values
    localparam logic [7:0]  AREA_USER       = 8'h00;
    localparam logic [7:0]  AREA_EXTRA      = 8'h01;
    localparam logic [7:0]  SEQ_CLEAR       = 8'h00;
    localparam logic [7:0]  CMD_WRITE       = 8'h81;
    localparam logic [7:0]  CMD_VERIFY_CF   = 8'h82;
    localparam logic [7:0]  CMD_VERIFY_DF   = 8'h8A;
    localparam logic [7:0]  CMD_BLANK_CF    = 8'h83;
    localparam logic [7:0]  CMD_BLANK_DF    = 8'h8B;
    localparam logic [7:0]  CMD_ERASE       = 8'h84;
    localparam logic [7:0]  XCMD_SECURITY   = 8'h81;
    localparam logic [7:0]  XCMD_SHIELD     = 8'h82;
    localparam logic [7:0]  PROT_KEY_VALUE  = 8'hA5;
    localparam logic [7:0]  MODE_NONPROG    = 8'h08;
    localparam logic [7:0]  MODE_CF_PROG    = 8'h82;
    localparam logic [7:0]  MODE_DF_PROG    = 8'h10;
    localparam logic [7:0]  MODE_STEP_1     = 8'h12;
    localparam logic [7:0]  MODE_STEP_2     = 8'h92;
    localparam logic [7:0]  MODE_STEP_1_INV = 8'hED;
    localparam logic [7:0]  MODE_STEP_2_INV = 8'h6D;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUSY, SEQ_DONE} fsq_seq_t;
    typedef enum logic [1:0] {PROT_OFF, PROT_FIRST, PROT_INVERSE, PROT_REPEAT} fsq_prot_t;
endpackage : fsq_pkg

//--- hw/fsq_ctrl.sv
// Operation
// R1: Data flash reads pass only when enabled
// R2: Area select 0x00 user, 0x01 extra
// R3: Main start bit launches selected command
// R4: Main accepts 0x81 write, 0x84 erase
// R5: Main decodes verify and blank check commands
// R6: Writing 0x00 clears main sequencer settings
// R7: Stop bit aborts running main operation
// R8: Extra start bit launches selected command
// R9: Extra decodes shield window, security; 0x00 clears
// R10: Key 0xA5 opens protected write sequence
// R11: Broken protected sequence sets protect error
// R12: Mode values 0x08, 0x82, 0x10
// R13: Mode transitions use 0x12, 0x92 and inverses
// R14: Extra done set on completion, cleared with start
// R15: Main done set on completion, cleared with start
// R16: Completion errors reported in low status byte
// R17: Software waits for done, then clears start
module fsq_ctrl
    import fsq_pkg::*;
(
    input  wire logic              hclk,            // Bus clock
    input  wire logic              hresetn,         // Async reset, low active
    input  wire logic              hsel,            // Slave select
    input  wire logic [ADDR_W-1:0] haddr,           // Byte address
    input  wire logic [1:0]        htrans,          // Transfer type
    input  wire logic              hwrite,          // Write when high
    input  wire logic [2:0]        hsize,           // Transfer size, word only
    input  wire logic              hready,          // Bus ready
    input  wire logic [31:0]       hwdata,          // Write data
    output logic [31:0]            hrdata,          // Read data
    output logic                   hreadyout,       // Slave ready
    output logic                   hresp,           // Always OKAY
    output logic                   irq,             // Level interrupt
    input  wire logic              df_read_req,     // Data flash read request
    output logic                   df_read_grant,   // Data flash read allowed
    output logic                   area_extra,      // Extra area targeted
    output logic [7:0]             flash_mode,      // Programming mode value
    output logic                   main_op_start,   // Main operation launch pulse
    output logic [3:0]             main_op_cmd,     // Main command, bit 3 data flash
    output logic                   main_op_abort,   // Main forced stop pulse
    input  wire logic              main_op_done,    // Main operation finished
    input  wire logic              main_op_fail,    // Main operation failed, with done
    output logic                   extra_op_start,  // Extra operation launch pulse
    output logic [2:0]             extra_op_cmd,    // Extra command
    input  wire logic              extra_op_done,   // Extra operation finished
    input  wire logic              extra_op_fail    // Extra operation failed, with done
);

    typedef struct packed {
        logic              dp_sel;
        logic              dp_write;
        logic              dp_wait;
        logic [ADDR_W-1:0] dp_addr;
        logic [31:0]       rdata;
        logic              df_enable;
        logic [7:0]        area;
        logic [7:0]        main_ctrl;
        logic [7:0]        extra_ctrl;
        fsq_seq_t          main_state;
        fsq_seq_t          extra_state;
        logic [7:0]        mode;
        fsq_prot_t         prot_step;
        logic [7:0]        prot_val;
        logic              prot_error;
        logic              main_done;
        logic              extra_done;
        logic [5:0]        err;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_mask;
        logic              main_start;
        logic              main_abort;
        logic              extra_start;
    } fsq_state_t;

    fsq_state_t s;
    fsq_state_t n;

    function automatic logic main_cmd_valid(input logic [7:0] v);
        return v == CMD_WRITE || v == CMD_ERASE || v == CMD_VERIFY_CF || v == CMD_VERIFY_DF ||
               v == CMD_BLANK_CF || v == CMD_BLANK_DF;  // [R4] [R5]
    endfunction : main_cmd_valid

    function automatic int main_err_bit(input logic [7:0] v);
        case (v)
            CMD_WRITE:                    return ERR_WRITE_BIT;
            CMD_VERIFY_CF, CMD_VERIFY_DF: return ERR_VERIFY_BIT;
            CMD_BLANK_CF, CMD_BLANK_DF:   return ERR_BLANK_BIT;
            default:                      return ERR_ERASE_BIT;
        endcase
    endfunction : main_err_bit

    logic       wr;
    logic [7:0] wd;
    logic       rd_capture;
    logic       prot_fault;
    logic       ev_main;
    logic       ev_extra;
    logic [7:0] status_low;

    always_comb begin
        wr         = s.dp_sel && s.dp_write;
        wd         = hwdata[7:0];
        rd_capture = s.dp_sel && !s.dp_write && !s.dp_wait;
        status_low = {2'b00, s.err};
    end

    always_comb begin
        n             = s;
        n.main_start  = 1'b0;
        n.main_abort  = 1'b0;
        n.extra_start = 1'b0;
        prot_fault    = 1'b0;
        ev_main       = 1'b0;
        ev_extra      = 1'b0;

        // Reads take one wait state so a write just before is already visible
        if (rd_capture) begin
            n.dp_wait = 1'b1;
            case (s.dp_addr)
                OFS_DF_ACCESS:   n.rdata = {31'd0, s.df_enable};
                OFS_AREA_SELECT: n.rdata = {24'd0, s.area};
                OFS_MAIN_SEQ:    n.rdata = {24'd0, s.main_ctrl};
                OFS_EXTRA_SEQ:   n.rdata = {24'd0, s.extra_ctrl};
                OFS_PROT_STATUS: n.rdata = {31'd0, s.prot_error};
                OFS_PROG_MODE:   n.rdata = {24'd0, s.mode};
                OFS_STATUS_HIGH: n.rdata = {24'd0, s.extra_done, s.main_done, 6'd0};
                OFS_STATUS_LOW:  n.rdata = {24'd0, status_low};
                OFS_IRQ_STATUS:  n.rdata = {29'd0, s.irq_status};
                OFS_IRQ_MASK:    n.rdata = {29'd0, s.irq_mask};
                default:         n.rdata = WORD_ZERO;
            endcase
            if (s.dp_addr == OFS_IRQ_STATUS) begin
                n.irq_status = '0;
            end
        end
        if (s.dp_sel && (s.dp_write || s.dp_wait)) begin
            n.dp_sel  = 1'b0;
            n.dp_wait = 1'b0;
        end

        if (wr) begin
            case (s.dp_addr)
                OFS_DF_ACCESS:   n.df_enable = wd[DF_ENABLE_BIT];  // [R1]
                OFS_AREA_SELECT: n.area      = wd;                 // [R2]
                OFS_IRQ_MASK:    n.irq_mask  = wd[IRQ_W-1:0];
                default:         n.area      = n.area;
            endcase
        end

        // Protected sequence: key, value, inverse, value again
        if (wr && s.dp_addr == OFS_PROT_KEY) begin
            if (wd == PROT_KEY_VALUE) begin
                n.prot_step  = PROT_FIRST;                         // [R10]
                n.prot_error = 1'b0;
            end else begin
                prot_fault  = 1'b1;
                n.prot_step = PROT_OFF;
            end
        end else if (wr && s.dp_addr == OFS_PROG_MODE) begin
            case (s.prot_step)
                PROT_FIRST: begin
                    n.prot_val  = wd;
                    n.prot_step = PROT_INVERSE;
                end
                PROT_INVERSE: begin
                    if (wd == ~s.prot_val) begin
                        n.prot_step = PROT_REPEAT;                 // [R13]
                    end else begin
                        prot_fault  = 1'b1;
                        n.prot_step = PROT_OFF;
                    end
                end
                PROT_REPEAT: begin
                    if (wd == s.prot_val) begin
                        n.mode = wd;                               // [R12] [R13]
                    end else begin
                        prot_fault = 1'b1;
                    end
                    n.prot_step = PROT_OFF;
                end
                default: prot_fault = 1'b1;
            endcase
        end else if (wr && s.prot_step != PROT_OFF) begin
            prot_fault  = 1'b1;
            n.prot_step = PROT_OFF;
        end
        if (prot_fault) begin
            n.prot_error = 1'b1;                                   // [R11]
        end

        case (s.main_state)
            SEQ_IDLE: begin
                if (wr && s.dp_addr == OFS_MAIN_SEQ) begin
                    n.main_ctrl = wd;
                    if (wd[SEQ_START_BIT]) begin                   // [R3]
                        if (main_cmd_valid(wd) && s.mode != MODE_NONPROG) begin
                            n.main_start = 1'b1;
                            n.main_state = SEQ_BUSY;
                        end else begin
                            // Unknown command or wrong mode ends at once with an error
                            n.err[ERR_MAIN_BIT] = 1'b1;            // [R16]
                            n.main_done         = 1'b1;
                            ev_main             = 1'b1;
                            n.main_state        = SEQ_DONE;
                        end
                    end
                end
            end
            SEQ_BUSY: begin
                if (wr && s.dp_addr == OFS_MAIN_SEQ && wd[SEQ_STOP_BIT]) begin
                    n.main_abort        = 1'b1;                    // [R7]
                    n.main_ctrl[SEQ_STOP_BIT] = 1'b1;
                    n.err[ERR_MAIN_BIT] = 1'b1;
                    n.main_done         = 1'b1;
                    ev_main             = 1'b1;
                    n.main_state        = SEQ_DONE;
                end else if (main_op_done) begin
                    if (main_op_fail) begin
                        n.err[main_err_bit(s.main_ctrl)] = 1'b1;   // [R16]
                    end
                    n.main_done  = 1'b1;                           // [R15]
                    ev_main      = 1'b1;
                    n.main_state = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                if (wr && s.dp_addr == OFS_MAIN_SEQ) begin
                    n.main_ctrl = wd;                              // [R6]
                    if (!wd[SEQ_START_BIT]) begin
                        n.main_done = 1'b0;                        // [R15] [R17]
                        n.err[ERR_MAIN_BIT:ERR_ERASE_BIT] = '0;
                        n.main_state = SEQ_IDLE;
                    end
                end
            end
            default: n.main_state = SEQ_IDLE;
        endcase

        case (s.extra_state)
            SEQ_IDLE: begin
                if (wr && s.dp_addr == OFS_EXTRA_SEQ) begin
                    n.extra_ctrl = wd;
                    if (wd[SEQ_START_BIT]) begin                   // [R8]
                        if (wd == XCMD_SHIELD || wd == XCMD_SECURITY) begin  // [R9]
                            n.extra_start = 1'b1;
                            n.extra_state = SEQ_BUSY;
                        end else begin
                            n.err[ERR_EXTRA_BIT] = 1'b1;
                            n.extra_done         = 1'b1;
                            ev_extra             = 1'b1;
                            n.extra_state        = SEQ_DONE;
                        end
                    end
                end
            end
            SEQ_BUSY: begin
                if (extra_op_done) begin
                    if (extra_op_fail) begin
                        n.err[ERR_EXTRA_BIT] = 1'b1;               // [R16]
                    end
                    n.extra_done  = 1'b1;                          // [R14]
                    ev_extra      = 1'b1;
                    n.extra_state = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                if (wr && s.dp_addr == OFS_EXTRA_SEQ) begin
                    n.extra_ctrl = wd;                             // [R9]
                    if (!wd[SEQ_START_BIT]) begin
                        n.extra_done         = 1'b0;               // [R14] [R17]
                        n.err[ERR_EXTRA_BIT] = 1'b0;
                        n.extra_state        = SEQ_IDLE;
                    end
                end
            end
            default: n.extra_state = SEQ_IDLE;
        endcase

        // Events after the read clear so a same-cycle set wins
        if (ev_main) begin
            n.irq_status[IRQ_MAIN_BIT] = 1'b1;
        end
        if (ev_extra) begin
            n.irq_status[IRQ_EXTRA_BIT] = 1'b1;
        end
        if (prot_fault) begin
            n.irq_status[IRQ_PROT_BIT] = 1'b1;
        end

        // Address phase
        if (hsel && hready && htrans[1]) begin
            n.dp_sel   = 1'b1;
            n.dp_write = hwrite;
            n.dp_wait  = 1'b0;
            n.dp_addr  = {haddr[ADDR_W-1:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s             <= '0;
            s.main_state  <= SEQ_IDLE;
            s.extra_state <= SEQ_IDLE;
            s.prot_step   <= PROT_OFF;
            s.mode        <= MODE_NONPROG;
            s.area        <= AREA_USER;
        end else begin
            s <= n;
        end
    end

    always_comb begin
        hrdata         = s.rdata;
        hreadyout      = !rd_capture;
        hresp          = 1'b0;
        irq            = |(s.irq_status & s.irq_mask);
        df_read_grant  = df_read_req && s.df_enable;   // [R1]
        area_extra     = s.area == AREA_EXTRA;         // [R2]
        flash_mode     = s.mode;
        main_op_start  = s.main_start;
        main_op_cmd    = s.main_ctrl[3:0];
        main_op_abort  = s.main_abort;
        extra_op_start = s.extra_start;
        extra_op_cmd   = s.extra_ctrl[2:0];
    end

endmodule : fsq_ctrl

//--- dv/fsq_ctrl_chk.sv
module fsq_ctrl_chk
    import fsq_pkg::*;
(
    input  wire logic              hclk,           // Clock
    input  wire logic              hresetn,        // Reset
    input  wire logic              hsel,           // Select
    input  wire logic [ADDR_W-1:0] haddr,          // Address
    input  wire logic [1:0]        htrans,         // Transfer
    input  wire logic              hwrite,         // Write
    input  wire logic              hready,         // Ready
    input  wire logic [31:0]       hwdata,         // Write data
    input  wire logic              df_read_req,    // Read req
    input  wire logic              df_read_grant,  // Read grant
    input  wire logic              area_extra,     // Extra area
    input  wire logic [7:0]        flash_mode,     // Mode
    input  wire logic              main_op_start,  // Main launch
    input  wire logic [3:0]        main_op_cmd,    // Main cmd
    input  wire logic              main_op_abort,  // Main stop
    input  wire logic              extra_op_start, // Extra launch
    input  wire logic [2:0]        extra_op_cmd    // Extra cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic              aph_w;
    logic [ADDR_W-1:0] aph_a;
    logic              wr_now;
    // Write data phase tracking: address is captured only while ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_w <= 1'b0;
            aph_a <= '0;
        end else if (hready) begin
            aph_w <= hsel && htrans[1] && hwrite;
            aph_a <= haddr;
        end
    end
    assign wr_now = aph_w && hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_dfen;
        wr_now && aph_a == OFS_DF_ACCESS |=> df_read_grant == (df_read_req && $past(hwdata[DF_ENABLE_BIT]));
    endproperty
    a_dfen: assert property (p_dfen)
        else $error("grant does not follow enable");
    property p_area;
        wr_now && aph_a == OFS_AREA_SELECT |=> area_extra == ($past(hwdata[7:0]) == AREA_EXTRA);
    endproperty
    a_area: assert property (p_area)
        else $error("area output wrong");
    property p_start;
        main_op_start |-> $past(wr_now && aph_a == OFS_MAIN_SEQ && hwdata[SEQ_START_BIT]);
    endproperty
    a_start: assert property (p_start)
        else $error("main start without start write");
    property p_cmd;
        main_op_start |-> main_op_cmd inside {4'h1, 4'h2, 4'hA, 4'h3, 4'hB, 4'h4};
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("main start with bad command");
    property p_bad;
        wr_now && aph_a == OFS_MAIN_SEQ && hwdata[7] && !hwdata[6] && hwdata[2:0] > 3'd4 |=> !main_op_start;
    endproperty
    a_bad: assert property (p_bad)
        else $error("unknown command launched");
    property p_abort;
        main_op_abort |-> $past(wr_now && aph_a == OFS_MAIN_SEQ && hwdata[SEQ_STOP_BIT]);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort without stop write");
    property p_xstart;
        extra_op_start |-> $past(wr_now && aph_a == OFS_EXTRA_SEQ && hwdata[7]) && extra_op_cmd inside {3'd1, 3'd2};
    endproperty
    a_xstart: assert property (p_xstart)
        else $error("extra start wrong");
    property p_mode;
        $changed(flash_mode) |-> $past(wr_now && aph_a == OFS_PROG_MODE);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode changed without write");
endmodule : fsq_ctrl_chk

//--- dv/fsq_ctrl_tb.sv
module fsq_ctrl_tb
    import fsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_n = 1'b0, rd_ph = 1'b0;
    logic        df_read_req = 1'b0, main_op_done = 1'b0, main_op_fail = 1'b0, extra_op_done = 1'b0;
    logic        extra_op_fail = 1'b0, hreadyout, hresp, irq, df_read_grant, area_extra;
    logic        main_op_start, main_op_abort, extra_op_start;
    logic [7:0]  haddr = 8'h00, flash_mode;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010, extra_op_cmd;
    logic [3:0]  main_op_cmd;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, r;
    logic [31:0] exp_q[$];
    int          err_count = 0, cmp_count = 0, n_start = 0, n_abort = 0, n_xstart = 0;
    always #5 hclk = ~hclk;
    fsq_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
        .hrdata, .hreadyout, .hresp, .irq, .df_read_req, .df_read_grant, .area_extra, .flash_mode,
        .main_op_start, .main_op_cmd, .main_op_abort, .main_op_done, .main_op_fail, .extra_op_start,
        .extra_op_cmd, .extra_op_done, .extra_op_fail);
    task chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // Outputs sampled mid-cycle, where registered values have settled
    always @(negedge hclk) begin
        rdy_n <= hreadyout;
        if (main_op_start === 1'b1) n_start <= n_start + 1;
        if (main_op_abort === 1'b1) n_abort <= n_abort + 1;
        if (extra_op_start === 1'b1) n_xstart <= n_xstart + 1;
        if (rd_ph && hreadyout === 1'b1) begin
            rd_ph <= 1'b0;
            chk(exp_q.size() > 0 && hrdata === exp_q[0] && hresp === 1'b0, "read data");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) rd_ph <= 1'b1;
    end
    task wt;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_n !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(1'b0, "bus timeout");
            results();
        end
    endtask : wt
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wt();
        r = $urandom();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {r[23:0], d};
        wt();
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h00_0000, e});
        bus(1'b0, a, 8'h00);
    endtask : rd
    task fin(input bit x, input bit f);
        @(posedge hclk);
        extra_op_done <= x;
        extra_op_fail <= x & f;
        main_op_done <= !x;
        main_op_fail <= !x & f;
        @(posedge hclk);
        {extra_op_done, extra_op_fail, main_op_done, main_op_fail} <= 4'h0;
    endtask : fin
    initial begin
        static logic [7:0] mc [6] = '{CMD_WRITE, CMD_VERIFY_CF, CMD_VERIFY_DF, CMD_BLANK_CF, CMD_BLANK_DF, CMD_ERASE};
        static int         eb [6] = '{ERR_WRITE_BIT, ERR_VERIFY_BIT, ERR_VERIFY_BIT, ERR_BLANK_BIT, ERR_BLANK_BIT,
                                      ERR_ERASE_BIT};
        static logic [7:0] pm [3] = '{MODE_STEP_1, MODE_STEP_2, MODE_CF_PROG};
        static logic [7:0] xc [2] = '{XCMD_SECURITY, XCMD_SHIELD};
        bit                fl;
        void'($urandom(32'h3cceb3c5));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 'h30; a += 4) rd(8'(a), a == OFS_PROG_MODE ? MODE_NONPROG : 8'h00);
        df_read_req <= 1'b1;
        wr(OFS_DF_ACCESS, 8'h01);
        @(negedge hclk) chk(df_read_grant === 1'b1, "grant on");
        wr(OFS_DF_ACCESS, 8'h00);
        @(negedge hclk) chk(df_read_grant === 1'b0, "grant off");
        wr(OFS_AREA_SELECT, AREA_EXTRA);
        @(negedge hclk) chk(area_extra === 1'b1, "extra area");
        wr(OFS_AREA_SELECT, AREA_USER);
        @(negedge hclk) chk(area_extra === 1'b0, "user area");
        // Commands are refused while non-programmable
        wr(OFS_MAIN_SEQ, CMD_WRITE);
        rd(OFS_STATUS_LOW, 8'h10);
        wr(OFS_MAIN_SEQ, SEQ_CLEAR);
        wr(OFS_PROG_MODE, MODE_DF_PROG);
        rd(OFS_PROT_STATUS, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_PROT_KEY, PROT_KEY_VALUE);
            rd(OFS_PROT_STATUS, 8'h00);
            wr(OFS_PROG_MODE, pm[i]);
            wr(OFS_PROG_MODE, ~pm[i]);
            wr(OFS_PROG_MODE, pm[i]);
            rd(OFS_PROG_MODE, pm[i]);
        end
        @(negedge hclk) chk(flash_mode === MODE_CF_PROG, "mode port");
        // Second value not inverted breaks the sequence
        wr(OFS_PROT_KEY, PROT_KEY_VALUE);
        wr(OFS_PROG_MODE, MODE_DF_PROG);
        wr(OFS_PROG_MODE, MODE_DF_PROG);
        rd(OFS_PROT_STATUS, 8'h01);
        rd(OFS_PROG_MODE, MODE_CF_PROG);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_MAIN_SEQ, mc[i]);
            // Fail bit kept apart: every later bus call draws fresh random data
            fl = r[0];
            fin(1'b0, fl);
            chk(main_op_cmd === mc[i][3:0] && n_start == i + 1, "main launch");
            rd(OFS_STATUS_HIGH, 8'h40);
            rd(OFS_STATUS_LOW, fl ? 8'(1 << eb[i]) : 8'h00);
            wr(OFS_MAIN_SEQ, SEQ_CLEAR);
            rd(OFS_STATUS_HIGH, 8'h00);
            rd(OFS_STATUS_LOW, 8'h00);
        end
        wr(OFS_MAIN_SEQ, 8'h85);
        rd(OFS_STATUS_LOW, 8'h10);
        wr(OFS_MAIN_SEQ, SEQ_CLEAR);
        wr(OFS_MAIN_SEQ, CMD_ERASE);
        wr(OFS_MAIN_SEQ, CMD_ERASE | 8'h40);
        rd(OFS_STATUS_HIGH, 8'h40);
        rd(OFS_STATUS_LOW, 8'h10);
        chk(n_abort == 1 && n_start == 7, "forced stop");
        wr(OFS_MAIN_SEQ, SEQ_CLEAR);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_EXTRA_SEQ, xc[i]);
            fl = r[0];
            fin(1'b1, fl);
            chk(extra_op_cmd === xc[i][2:0] && n_xstart == i + 1, "extra launch");
            rd(OFS_STATUS_HIGH, 8'h80);
            rd(OFS_STATUS_LOW, fl ? 8'h20 : 8'h00);
            wr(OFS_EXTRA_SEQ, SEQ_CLEAR);
            rd(OFS_STATUS_HIGH, 8'h00);
        end
        // All three events have fired by now; mask still zero
        @(negedge hclk) chk(irq === 1'b0, "irq masked");
        wr(OFS_IRQ_MASK, 8'h07);
        @(negedge hclk) chk(irq === 1'b1, "irq raised");
        rd(OFS_IRQ_STATUS, 8'h07);
        @(negedge hclk) chk(irq === 1'b0, "irq cleared");
        rd(OFS_IRQ_STATUS, 8'h00);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_PROG_MODE, MODE_NONPROG);
        chk(exp_q.size() == 0, "reads left over");
        results();
    end
endmodule : fsq_ctrl_tb
bind fsq_ctrl fsq_ctrl_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
    .df_read_req, .df_read_grant, .area_extra, .flash_mode, .main_op_start, .main_op_cmd, .main_op_abort,
    .extra_op_start, .extra_op_cmd);
